// file: hdl/tmw_timer.sv
// 16-bit capture/compare timer with mode register, Avalon-MM slave
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`include "tmw_consts.svh"

// Summary of operation
// - an external count clock input can drive the counter instead of internal clocks.
// - pin A is compare output or capture input of general register A.
// - pins B, C, D are compare out, capture in, or PWM out.
// - mode bit 7 starts the counter, resets to 0, counting only when 1.
// - buffer-B bit 0 makes register D independent, 1 makes it B's buffer.
// - buffer-A bit 0 makes register C independent, 1 makes it A's buffer.
// - mode bit 3 is reserved and always reads as 1.
// - PWM-D bit 0 gives normal compare on pin D, 1 gives PWM.
// - PWM-C bit 0 gives normal compare on pin C, 1 gives PWM.
// - mode bit 0 selects normal compare or PWM on pin B, reset 0.
// - with start bit 0 the counter holds its value.
// - counter clock picks from four system clock divisions or external input.
// - a compare match on register A can clear the counter, setting PWM period.
module tmw_timer
    import tmw_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // avalon-mm slave
    input  wire logic [2:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // external count clock
    input  wire logic             ext_count_clock_in,
    // channel pins, output enable low while driving
    input  wire logic             channel_a_pin_i,
    output logic                  channel_a_pin_o,
    output logic                  channel_a_pin_oe_n,
    input  wire logic             channel_b_pin_i,
    output logic                  channel_b_pin_o,
    output logic                  channel_b_pin_oe_n,
    input  wire logic             channel_c_pin_i,
    output logic                  channel_c_pin_o,
    output logic                  channel_c_pin_oe_n,
    input  wire logic             channel_d_pin_i,
    output logic                  channel_d_pin_o,
    output logic                  channel_d_pin_oe_n
);
    typedef struct packed {
        logic [7:0]       mode;
        logic [11:0]      iosel;
        logic [CNT_W-1:0] cnt;
        logic [3:0][CNT_W-1:0] gr;
        logic [3:0]       pin_in;
        logic [3:0]       pin_out;
        logic             ack;
        logic [31:0]      rdata;
    } tmw_state_t;

    tmw_state_t s_q;
    tmw_state_t s_d;
    tmw_tick_if tk ();

    // ------------------------------------------------------------
    // register map, word index on avs_address
    // ------------------------------------------------------------
    //   0  mode: start, buffer pair a/b, pwm select b/c/d
    //   1  io select: direction per channel, clock source, clear
    //   2  counter value, writable while running
    //   3  general register a, also the pwm period
    //   4  general register b
    //   5  general register c, buffer of a when paired
    //   6  general register d, buffer of b when paired
    //   7  unmapped: reads zero, writes dropped
    //
    // io select layout
    //   bit 2n     channel n direction, 1 = capture input
    //   bits 10:8  clock source, codes 4..7 act as external
    //   bit 11     clear the counter on a register a match
    //
    // bus timing
    //   every access costs two cycles: waitrequest is high in the
    //   first, a write lands at its closing edge, and read data
    //   stand in the second only; the ack bit keeps a held
    //   request from being taken twice
    //   read data are zero outside the answer cycle, so a bus
    //   monitor never sees stale values
    //
    // counting
    //   the counter moves only on a prescaler tick while the start
    //   bit is set; a bus write to the counter wins over the tick
    //   a match is judged on tick cycles against the value before
    //   the increment, so a pin changes as the counter leaves it
    //   limitation: the counter wraps silently, no overflow flag
    //
    // capture
    //   rising pin edges only, seen two cycles after the pin moves
    //   because the level passes through two history stages
    //   in a pair the older value drops into the buffer register,
    //   and the buffer's own pin is ignored
    //
    // pwm
    //   pins b, c and d drop at the register a match and rise at
    //   their own match; a pwm pin is always driven, whatever its
    //   direction bit says
    //   limitation: a duty value above the period never rises
    //
    // reset
    //   mode reads back 0x48, general registers hold all ones,
    //   every pin starts as a driven output at level zero

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    tmw_prescale u_ps (
        .clock              (clock),
        .resetn             (resetn),
        .ext_count_clock_in (ext_count_clock_in),
        .tk                 (tk)
    );

    // clock select field; codes above the last source fall back to external
    assign tk.sel = (s_q.iosel[`TMW_CLKSEL_LSB+2:`TMW_CLKSEL_LSB] > 3'h4) ? TMW_CLK_EXT
                  : tmw_clksel_t'(s_q.iosel[`TMW_CLKSEL_LSB+2:`TMW_CLKSEL_LSB]);

    // merge a bus write into a stored word under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic             run;
    logic             tick;
    logic [3:0]       pwm;
    logic [3:0]       is_in;
    logic [3:0]       rise;
    logic [3:0]       match;
    logic [CNT_W-1:0] cnt_nx;
    logic             wr;
    logic             rd;
    logic [31:0]      cur;
    logic [31:0]      nw;

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    assign run  = s_q.mode[`TMW_BIT_START];
    assign tick = run & tk.tick;
    assign pwm  = {s_q.mode[`TMW_BIT_PWM_SEL_D], s_q.mode[`TMW_BIT_PWM_SEL_C],
                   s_q.mode[`TMW_BIT_PWM_SEL_B], 1'b0};
    assign wr   = avs_write & ~s_q.ack;
    assign rd   = avs_read & ~s_q.ack;

    // per-channel direction: a PWM channel is always an output
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            is_in[i] = (s_q.iosel[2*i] != `TMW_IOS_OUT) & ~pwm[i];
            rise[i]  = is_in[i] & s_q.pin_in[i] & ~s_q.pin_out[i];
            match[i] = tick & ~is_in[i] & (s_q.cnt == s_q.gr[i]);
        end
    end

    // clear on register A match gives the PWM period
    assign cnt_nx = (match[0] & s_q.iosel[`TMW_CLEAR_BIT]) ? `TMW_CNT_RST
                  : s_q.cnt + 16'h0001;

    // word currently addressed, as read back
    always_comb begin
        unique case (avs_address)
            `TMW_IDX_MODE:  cur = {24'h0, s_q.mode | `TMW_MODE_RSVMASK};
            `TMW_IDX_IOSEL: cur = {20'h0, s_q.iosel};
            `TMW_IDX_COUNT: cur = {16'h0, s_q.cnt};
            `TMW_IDX_GRA:   cur = {16'h0, s_q.gr[0]};
            `TMW_IDX_GRB:   cur = {16'h0, s_q.gr[1]};
            `TMW_IDX_GRC:   cur = {16'h0, s_q.gr[2]};
            `TMW_IDX_GRD:   cur = {16'h0, s_q.gr[3]};
            default:        cur = 32'h0;
        endcase
        nw = merge(cur, avs_writedata, avs_byteenable);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.ack    = (avs_read | avs_write) & ~s_q.ack;
        s_d.rdata  = rd ? cur : 32'h0;
        // delayed pin level reused as edge history for capture
        s_d.pin_out = s_q.pin_in;
        s_d.pin_in = {channel_d_pin_i, channel_c_pin_i, channel_b_pin_i, channel_a_pin_i};

        if (tick) begin
            s_d.cnt = cnt_nx;
        end

        // capture loads the register; in buffer mode the old value shifts down
        for (int i = 0; i < 2; i++) begin
            if (rise[i]) begin
                s_d.gr[i] = s_q.cnt;
                if (s_q.mode[`TMW_BIT_BUFA + i]) begin
                    s_d.gr[i+2] = s_q.gr[i];
                end
            end else if (match[i] & s_q.mode[`TMW_BIT_BUFA + i]) begin
                // compare buffer: new compare value taken at the match
                s_d.gr[i] = s_q.gr[i+2];
            end
        end
        for (int i = 2; i < 4; i++) begin
            // a buffer register never captures on its own pin
            if (rise[i] & ~s_q.mode[`TMW_BIT_BUFA + i - 2]) begin
                s_d.gr[i] = s_q.cnt;
            end
        end

        // bus write wins over counting in the same cycle
        if (wr) begin
            unique case (avs_address)
                `TMW_IDX_MODE:  s_d.mode = (nw[7:0] & `TMW_MODE_WMASK) | `TMW_MODE_RSVMASK;
                `TMW_IDX_IOSEL: s_d.iosel = nw[11:0];
                `TMW_IDX_COUNT: s_d.cnt = nw[CNT_W-1:0];
                `TMW_IDX_GRA:   s_d.gr[0] = nw[CNT_W-1:0];
                `TMW_IDX_GRB:   s_d.gr[1] = nw[CNT_W-1:0];
                `TMW_IDX_GRC:   s_d.gr[2] = nw[CNT_W-1:0];
                `TMW_IDX_GRD:   s_d.gr[3] = nw[CNT_W-1:0];
                default:        s_d.mode = s_q.mode;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q       <= '0;
            s_q.mode  <= `TMW_MODE_RST;
            s_q.gr    <= {4{`TMW_GR_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    // output level register per pin: toggle on match, PWM clears at clear point
    logic [3:0] lvl_q;
    logic [3:0] lvl_d;
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 1; i < 4; i++) begin
            if (pwm[i] & match[0]) begin
                lvl_d[i] = 1'b0;  // period start
            end else if (pwm[i] & match[i]) begin
                lvl_d[i] = 1'b1;  // duty point
            end else if (~pwm[i] & match[i]) begin
                lvl_d[i] = ~lvl_q[i];
            end
        end
        if (match[0]) begin
            lvl_d[0] = ~lvl_q[0];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lvl_q <= 4'h0;
        end else begin
            lvl_q <= lvl_d;
        end
    end

    // ------------------------------------------------------------
    // pins and bus outputs
    // ------------------------------------------------------------
    assign channel_a_pin_o    = lvl_q[0];
    assign channel_a_pin_oe_n = is_in[0];
    assign channel_b_pin_o    = lvl_q[1];
    assign channel_b_pin_oe_n = is_in[1];
    assign channel_c_pin_o    = lvl_q[2];
    assign channel_c_pin_oe_n = is_in[2];
    assign channel_d_pin_o    = lvl_q[3];
    assign channel_d_pin_oe_n = is_in[3];
    // one wait cycle per access, answer in the next
    assign avs_waitrequest    = (avs_read | avs_write) & ~s_q.ack;
    assign avs_readdata       = s_q.rdata;
endmodule

// file: hdl/tmw_consts.svh
// constants for the timer pins and mode control block
`ifndef TMW_CONSTS_SVH
`define TMW_CONSTS_SVH

// ------------------------------------------------------------
// register map (word index, byte address is index times four)
// ------------------------------------------------------------
`define TMW_IDX_MODE      3'h0
`define TMW_IDX_IOSEL     3'h1
`define TMW_IDX_COUNT     3'h2
`define TMW_IDX_GRA       3'h3
`define TMW_IDX_GRB       3'h4
`define TMW_IDX_GRC       3'h5
`define TMW_IDX_GRD       3'h6

// ------------------------------------------------------------
// mode register fields and reset values
// ------------------------------------------------------------
`define TMW_BIT_START     7
`define TMW_BIT_RSV6      6
`define TMW_BIT_BUFB      5
`define TMW_BIT_BUFA      4
`define TMW_BIT_RSV3      3
`define TMW_BIT_PWM_SEL_D      2
`define TMW_BIT_PWM_SEL_C      1
`define TMW_BIT_PWM_SEL_B      0
`define TMW_MODE_RST      8'h48
`define TMW_MODE_WMASK    8'hb7
`define TMW_MODE_RSVMASK  8'h48

// ------------------------------------------------------------
// io select register fields: channel n uses bit 2n
// ------------------------------------------------------------
`define TMW_IOS_OUT       1'b0
`define TMW_CLKSEL_LSB    8
`define TMW_CLEAR_BIT     11
`define TMW_GR_RST        16'hffff
`define TMW_CNT_RST       16'h0000

`endif

// file: hdl/tmw_pkg.sv
// types shared by the timer pins and mode control block
package tmw_pkg;
    // counter clock source selector
    typedef enum logic [2:0] {
        TMW_CLK_DIV1,
        TMW_CLK_DIV2,
        TMW_CLK_DIV4,
        TMW_CLK_DIV8,
        TMW_CLK_EXT
    } tmw_clksel_t;
endpackage

// file: hdl/tmw_tick_if.sv
// count tick carrier between prescaler and timer core
interface tmw_tick_if;
    logic        tick;
    tmw_pkg::tmw_clksel_t sel;
    modport src (output tick, input sel);
    modport dst (input tick, output sel);
endinterface

// file: hdl/tmw_prescale.sv
// prescaler producing the counter tick from five clock sources
module tmw_prescale
    import tmw_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // external count clock, synchronous to clock
    input  wire logic ext_count_clock_in,
    // tick carrier
    tmw_tick_if.src   tk
);
    typedef struct packed {
        logic [2:0] div;
        logic       ext;
    } tmw_ps_state_t;

    tmw_ps_state_t s_q;
    tmw_ps_state_t s_d;

    // free running divider plus external edge history
    always_comb begin
        s_d     = s_q;
        s_d.div = s_q.div + 3'h1;
        s_d.ext = ext_count_clock_in;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // one tick per source period; external counts rising edges
    always_comb begin
        unique case (tk.sel)
            TMW_CLK_DIV1: tk.tick = 1'b1;
            TMW_CLK_DIV2: tk.tick = s_q.div[0];
            TMW_CLK_DIV4: tk.tick = &s_q.div[1:0];
            TMW_CLK_DIV8: tk.tick = &s_q.div;
            TMW_CLK_EXT:  tk.tick = ext_count_clock_in & ~s_q.ext;
            default:      tk.tick = 1'b0;
        endcase
    end
endmodule

// file: verif/tmw_timer_sva.sv
// assertion checker for the timer pins and mode control block
`include "tmw_consts.svh"

// ------------------------------------------------------------
// bus and pin direction checks
// ------------------------------------------------------------
module tmw_timer_sva #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // bus
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // pin enables
    input wire logic        channel_a_pin_oe_n,
    input wire logic        channel_b_pin_oe_n,
    input wire logic        channel_c_pin_oe_n,
    input wire logic        channel_d_pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mode_q;
    logic [7:0] ios_q;
    logic [1:0] settle_q;
    logic       wr_ack;
    logic       quiet;
    assign wr_ack = avs_write && !avs_waitrequest && avs_byteenable[0];
    // pins may follow a write late, so they are judged only once settled
    assign quiet = !avs_write && settle_q == 2'h0;
    // shadow of mode and direction bits, taken at the ack edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_q   <= `TMW_MODE_RST;
            ios_q    <= 8'h00;
            settle_q <= 2'h0;
        end else begin
            if (wr_ack && avs_address == `TMW_IDX_MODE) mode_q <= avs_writedata[7:0];
            if (wr_ack && avs_address == `TMW_IDX_IOSEL) ios_q <= avs_writedata[7:0];
            settle_q <= avs_write ? 2'h3 : settle_q - 2'(settle_q != 2'h0);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_req_new; $rose(avs_read || avs_write); endsequence
    sequence s_rd_ack; avs_read && !avs_waitrequest; endsequence
    sequence s_rd_mode; s_rd_ack ##0 avs_address == `TMW_IDX_MODE; endsequence
    AST_WAIT_FIRST: assert property (s_req_new |-> avs_waitrequest)
        else $error("request not held off");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait longer than one cycle");
    AST_RD_ZERO: assert property (!(avs_read && !avs_waitrequest) |-> avs_readdata == 32'h0)
        else $error("read data outside ack");
    AST_MODE_RD: assert property (s_rd_mode |-> avs_readdata[7:0] == ((mode_q & `TMW_MODE_WMASK) | `TMW_MODE_RSVMASK))
        else $error("mode readback wrong");
    AST_MODE_RSV: assert property (s_rd_mode |-> avs_readdata[3])
        else $error("reserved bit read 0");
    AST_OE_A: assert property (quiet |-> channel_a_pin_oe_n == ios_q[0])
        else $error("pin a direction");
    AST_OE_B: assert property (quiet |-> channel_b_pin_oe_n == (ios_q[2] && !mode_q[0]))
        else $error("pin b direction");
    AST_OE_C: assert property (quiet |-> channel_c_pin_oe_n == (ios_q[4] && !mode_q[1]))
        else $error("pin c direction");
    AST_OE_D: assert property (quiet |-> channel_d_pin_oe_n == (ios_q[6] && !mode_q[2]))
        else $error("pin d direction");
endmodule

bind tmw_timer tmw_timer_sva #(.CNT_W(CNT_W)) i_tmw_timer_sva (.clock(clock), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .channel_a_pin_oe_n(channel_a_pin_oe_n),
    .channel_b_pin_oe_n(channel_b_pin_oe_n), .channel_c_pin_oe_n(channel_c_pin_oe_n),
    .channel_d_pin_oe_n(channel_d_pin_oe_n));

// file: verif/tmw_pin_model.sv
// far side of the channel pins and the external count clock
module tmw_pin_model (
    // clock
    input  wire logic       clock,
    // design side of the pins
    input  wire logic [3:0] pin_o,
    input  wire logic [3:0] pin_oe_n,
    // resolved wires
    output logic      [3:0] pin_i,
    output logic            ext_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] drv_q = 4'h0;
    initial ext_clk = 1'b0;
    // far side drives only while the design has let go of the pin
    assign pin_i = (pin_oe_n & drv_q) | (~pin_oe_n & pin_o);
    // count clock rests low between bursts
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock) ext_clk <= 1'b1;
            repeat (2) @(posedge clock);
            ext_clk <= 1'b0;
            repeat (2) @(posedge clock);
        end
    endtask
    task automatic set_pin(input int ch, input logic v);
        @(posedge clock) drv_q[ch] <= v;
        repeat (4) @(posedge clock);
    endtask
endmodule

// file: verif/tmw_timer_tb.sv
// self-checking bench for the timer pins and mode control block
`include "tmw_consts.svh"
module tmw_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic [2:0]  avs_address = 3'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ext_clk;
    logic [3:0]  pin_i, pin_o, pin_oe_n;
    logic [31:0] exp_q[$], msk_q[$];
    logic [31:0] lfsr = 32'hf800;
    logic [7:0]  mode_exp;
    int          errors = 0, samples_checked = 0, cycles = 0;
    // ------------------------------------------------------------
    // design, far side and clock
    // ------------------------------------------------------------
    tmw_timer i_tmw_timer (.clock(clock), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_count_clock_in(ext_clk),
        .channel_a_pin_i(pin_i[0]), .channel_a_pin_o(pin_o[0]), .channel_a_pin_oe_n(pin_oe_n[0]),
        .channel_b_pin_i(pin_i[1]), .channel_b_pin_o(pin_o[1]), .channel_b_pin_oe_n(pin_oe_n[1]),
        .channel_c_pin_i(pin_i[2]), .channel_c_pin_o(pin_o[2]), .channel_c_pin_oe_n(pin_oe_n[2]),
        .channel_d_pin_i(pin_i[3]), .channel_d_pin_o(pin_o[3]), .channel_d_pin_oe_n(pin_oe_n[3]));
    tmw_pin_model i_tmw_pin_model (.clock(clock), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pin_i(pin_i), .ext_clk(ext_clk));
    always #50 clock = ~clock;
    // a hang ends the run here
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            $display("unexpected %0t run too long", $time);
            summarize();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize;
        // a read note never answered counts against the run
        errors += exp_q.size();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] want, input logic [31:0] m);
        samples_checked++;
        if ((got & m) !== (want & m)) begin
            errors++;
            $display("unexpected %0t got %h want %h", $time, got, want);
        end
    endtask
    // pin levels are registered, so they stand until the next match
    task automatic cmp_pins(input logic [3:0] want, input logic [3:0] m);
        samples_checked++;
        if ((pin_o & m) !== (want & m)) begin
            errors++;
            $display("unexpected %0t pins %b want %b", $time, pin_o, want);
        end
    endtask
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    // start lands one edge in and stop two edges after the wait: forty counting edges
    task automatic run40(input logic [7:0] m);
        wr(`TMW_IDX_MODE, {24'h0, m});
        repeat (37) @(posedge clock);
        wr(`TMW_IDX_MODE, 32'h0);
    endtask
    // oldest note against each read answer, taken at the answering edge
    always @(posedge clock) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            cmp(avs_readdata, exp_q.pop_front(), msk_q.pop_front());
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rd(`TMW_IDX_MODE, 32'h48, 32'hff);
        rd(`TMW_IDX_COUNT, 32'h0, 32'hffff);
        rd(3'h7, 32'h0, 32'hffffffff);
        mode_exp = 8'h48;
        // random modes and directions, some lanes masked off
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            bus(1'b1, `TMW_IDX_IOSEL, {24'h0, lfsr[7:0]}, lfsr[19:16]);
            bus(1'b1, `TMW_IDX_MODE, {24'h0, lfsr[15:8]}, lfsr[23:20]);
            if (lfsr[20]) mode_exp = (lfsr[15:8] & 8'hb7) | 8'h48;
            rd(`TMW_IDX_MODE, {24'h0, mode_exp}, 32'hff);
            wr(3'h7, lfsr);
            rd(3'h7, 32'h0, 32'hffffffff);
        end
        // external clock counts only while started, codes 4 and 5
        for (int s = 4; s < 6; s++) begin
            wr(`TMW_IDX_MODE, 32'h0);
            wr(`TMW_IDX_IOSEL, s << `TMW_CLKSEL_LSB);
            wr(`TMW_IDX_COUNT, 32'h10);
            wr(`TMW_IDX_MODE, 32'h80);
            i_tmw_pin_model.pulse(5);
            wr(`TMW_IDX_MODE, 32'h0);
            i_tmw_pin_model.pulse(3);
            rd(`TMW_IDX_COUNT, 32'h15, 32'hffff);
        end
        // clear on a match, pin a toggles once
        wr(`TMW_IDX_COUNT, 32'h0);
        wr(`TMW_IDX_GRA, 32'h3);
        wr(`TMW_IDX_IOSEL, 32'hc00);
        wr(`TMW_IDX_MODE, 32'h80);
        i_tmw_pin_model.pulse(7);
        wr(`TMW_IDX_MODE, 32'h0);
        rd(`TMW_IDX_COUNT, 32'h3, 32'hffff);
        cmp_pins(4'h1, 4'h1);
        // capture alone, then with the buffer pair enabled
        for (int ch = 0; ch < 2; ch++) begin
            wr(`TMW_IDX_IOSEL, 32'h1 << (2 * ch));
            wr(`TMW_IDX_COUNT, 100 + ch);
            i_tmw_pin_model.set_pin(ch, 1'b1);
            rd(3'(`TMW_IDX_GRA + ch), 100 + ch, 32'hffff);
            rd(3'(`TMW_IDX_GRC + ch), 32'hffff, 32'hffff);
            wr(`TMW_IDX_MODE, 32'h10 << ch);
            wr(`TMW_IDX_COUNT, 200);
            i_tmw_pin_model.set_pin(ch, 1'b0);
            i_tmw_pin_model.set_pin(ch, 1'b1);
            rd(3'(`TMW_IDX_GRA + ch), 200, 32'hffff);
            rd(3'(`TMW_IDX_GRC + ch), 100 + ch, 32'hffff);
            wr(`TMW_IDX_MODE, 32'h0);
        end
        // internal divisions: forty edges give one tick per division period
        for (int k = 0; k < 4; k++) begin
            wr(`TMW_IDX_IOSEL, k << `TMW_CLKSEL_LSB);
            wr(`TMW_IDX_COUNT, 32'h0);
            run40(8'h80);
            rd(`TMW_IDX_COUNT, 40 >> k, 32'hffff);
        end
        // pwm on b, c and d with a period of seven; pin a toggles five times
        wr(`TMW_IDX_IOSEL, 32'h800);
        wr(`TMW_IDX_COUNT, 32'h0);
        wr(`TMW_IDX_GRA, 32'h6);
        wr(`TMW_IDX_GRB, 32'h2);
        wr(`TMW_IDX_GRC, 32'h4);
        wr(`TMW_IDX_GRD, 32'h5);
        run40(8'h87);
        rd(`TMW_IDX_COUNT, 32'h5, 32'hffff);
        cmp_pins(4'h6, 4'hf);
        repeat (3) @(posedge clock);
        summarize();
    end
endmodule
